// *** inc/sas_defs.svh ***
// Register offsets, field positions, reset values and timing counts of the sequencer
`ifndef SAS_DEFS_SVH
`define SAS_DEFS_SVH

// ----------------------------------------
// Register word offsets
// ----------------------------------------
`define SAS_OFF_CTRL 4'h0
`define SAS_OFF_CFG 4'h1
`define SAS_OFF_STAT 4'h2
`define SAS_OFF_RESULT 4'h3
`define SAS_OFF_IRQ_STAT 4'h4
`define SAS_OFF_IRQ_MASK 4'h5

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define SAS_CTRL_START 0
`define SAS_CTRL_ENABLE 1
`define SAS_CTRL_CONT 2

// ----------------------------------------
// Configuration register fields
// ----------------------------------------
`define SAS_CFG_CHAN_LSB 0
`define SAS_CFG_SCALE_LSB 4
`define SAS_CFG_MODE_LSB 8
`define SAS_CFG_AVG_LSB 12
`define SAS_CFG_REF_LSB 16
`define SAS_CFG_NEG_LSB 20
`define SAS_CFG_RST 32'h0000_0000

// ----------------------------------------
// Timing
// ----------------------------------------
`define SAS_SYS_CLK_HZ 20000000
`define SAS_SMP_CLK_HZ 4000000
`define SAS_CONV_SMP_CYCLES 20
`define SAS_SMP_DIV (`SAS_SYS_CLK_HZ / `SAS_SMP_CLK_HZ)
`define SAS_CONV_CYCLES (`SAS_CONV_SMP_CYCLES * `SAS_SMP_DIV)

`endif

// *** inc/sas_pkg.sv ***
// Types shared by the sequencer and its divider
package sas_pkg;
    typedef enum logic [1:0] {
        SAS_MODE_ABS = 2'b00,
        SAS_MODE_RATIO = 2'b01,
        SAS_MODE_PDIFF = 2'b10,
        SAS_MODE_RPDIFF = 2'b11
    } sas_mode_t;

    typedef enum logic [2:0] {
        SAS_ST_IDLE = 3'b000,
        SAS_ST_CONV = 3'b001,
        SAS_ST_NEXT = 3'b010,
        SAS_ST_DIV = 3'b011,
        SAS_ST_DONE = 3'b100
    } sas_state_t;

    typedef struct packed {
        logic [2:0] chan;
        logic [2:0] scale;
        logic [2:0] ref_chan;
        logic [2:0] neg_chan;
    } sas_sel_t;

    typedef struct packed {
        logic [3:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
    } sas_bus_req_t;
endpackage

// *** hw/sas_div.sv ***
// Sequential restoring divider giving a 10-bit fraction num/den
module sas_div
    import sas_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Request
    input wire logic start,
    input wire logic [10:0] num,
    input wire logic [9:0] den,
    // Answer
    output logic done,
    output logic [9:0] quot
);
    logic [11:0] rem, next_rem;
    logic [9:0] q, next_q;
    logic [3:0] cnt, next_cnt;
    logic busy, next_busy;
    logic next_done;
    logic [11:0] trial;

    always_comb begin
        next_rem = rem;
        next_q = q;
        next_cnt = cnt;
        next_busy = busy;
        next_done = 1'b0;
        trial = {rem[10:0], 1'b0};
        if (start) begin
            next_rem = {1'b0, num};
            next_q = 10'h000;
            next_cnt = 4'hA;
            next_busy = 1'b1;
        end else if (busy) begin
            if (trial >= {2'b00, den}) begin
                next_rem = trial - {2'b00, den};
                next_q = {q[8:0], 1'b1};
            end else begin
                next_rem = trial;
                next_q = {q[8:0], 1'b0};
            end
            next_cnt = cnt - 4'h1;
            if (cnt == 4'h1) begin
                next_busy = 1'b0;
                next_done = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rem <= 12'h000;
            q <= 10'h000;
            cnt <= 4'h0;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            rem <= next_rem;
            q <= next_q;
            cnt <= next_cnt;
            busy <= next_busy;
            done <= next_done;
        end
    end

    assign quot = q;
endmodule

// *** hw/sas_top.sv ***
// Successive-approximation converter sequencer with Avalon-MM registers
// Function
// - Results are 10-bit single-ended codes against ground.
// - Six-way selector: four external, temperature, battery supply voltage.
// - One conversion lasts 20 sample-clock cycles, 5 us at 4 MHz.
// - Eight scale settings apply only to external channels.
// - Absolute mode reports the code against the fixed reference.
// - Ratio mode converts twice, then divides signal by reference.
// - Pseudo-differential mode converts twice and reports the difference.
// - Ratio pseudo-differential converts thrice, divides difference by third.
// - Single mode runs one sequence per start; continuous repeats.
// - Busy bit is set during a sequence and cleared at its end.
// - Completion raises a maskable interrupt.
`include "sas_defs.svh"

module sas_top (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Analog front end
    output sas_pkg::sas_sel_t afe_sel,
    output logic afe_smp_clk,
    output logic afe_sample,
    input wire logic [9:0] afe_code,
    // Interrupt
    output logic irq
);
    import sas_pkg::*;

    // ----------------------------------------
    // Register state
    // ----------------------------------------
    logic enable, next_enable;
    logic cont, next_cont;
    logic start_req, next_start_req;
    logic [31:0] cfg, next_cfg;
    logic [9:0] result, next_result;
    logic irq_stat, next_irq_stat;
    logic irq_mask, next_irq_mask;
    logic [31:0] next_readdata;
    logic rd_ack, next_rd_ack;
    sas_bus_req_t req;

    // ----------------------------------------
    // Sequencer state
    // ----------------------------------------
    sas_state_t state, next_state;
    logic [7:0] cyc, next_cyc;
    logic [1:0] step, next_step;
    logic [3:0] avg_n, next_avg_n;
    logic [13:0] acc, next_acc;
    logic [9:0] conv_a, next_conv_a;
    logic [9:0] conv_b, next_conv_b;
    logic div_start, next_div_start;
    logic [10:0] div_num, next_div_num;
    logic [9:0] div_den, next_div_den;
    logic div_done;
    logic [9:0] div_quot;
    logic done_pulse;
    logic [9:0] code_s1, code_s2;
    logic [2:0] smp_div;
    sas_mode_t mode;
    logic [2:0] avg_log;
    logic [9:0] avg_code;
    logic [1:0] last_step;
    logic [10:0] diff;

    assign req = '{avs_address, avs_read, avs_write, avs_writedata};
    assign mode = sas_mode_t'(cfg[`SAS_CFG_MODE_LSB +: 2]);
    assign avg_log = {1'b0, cfg[`SAS_CFG_AVG_LSB +: 2]};
    assign avg_code = 10'(acc >> avg_log);
    assign diff = {1'b0, conv_a} - {1'b0, conv_b};

    // Channel picked at each step of a sequence
    function automatic logic [2:0] step_chan(input logic [1:0] s, input logic [31:0] c,
                                             input sas_mode_t m);
        case (s)
            2'd0: step_chan = c[`SAS_CFG_CHAN_LSB +: 3];
            2'd1: step_chan = (m == SAS_MODE_RATIO) ? c[`SAS_CFG_REF_LSB +: 3]
                                                  : c[`SAS_CFG_NEG_LSB +: 3];
            default: step_chan = c[`SAS_CFG_REF_LSB +: 3];
        endcase
    endfunction

    // Channel 0..3 external, 4 temperature, 5 battery supply voltage
    function automatic logic is_external(input logic [2:0] ch);
        is_external = (ch < 3'd4);
    endfunction

    always_comb begin
        case (mode)
            SAS_MODE_ABS: last_step = 2'd0;
            SAS_MODE_RATIO: last_step = 2'd1;
            SAS_MODE_PDIFF: last_step = 2'd1;
            default: last_step = 2'd2;
        endcase
    end

    // ----------------------------------------
    // Front end drive
    // ----------------------------------------
    always_comb begin
        afe_sel.chan = step_chan(step, cfg, mode);
        afe_sel.scale = is_external(afe_sel.chan) ? cfg[`SAS_CFG_SCALE_LSB +: 3] : 3'h0;
        afe_sel.ref_chan = cfg[`SAS_CFG_REF_LSB +: 3];
        afe_sel.neg_chan = cfg[`SAS_CFG_NEG_LSB +: 3];
    end
    assign afe_sample = (state == SAS_ST_CONV);
    assign afe_smp_clk = (smp_div < 3'(`SAS_SMP_DIV / 2)) && afe_sample;

    // Code from the analog side crosses in
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            code_s1 <= 10'h000;
            code_s2 <= 10'h000;
            smp_div <= 3'h0;
        end else begin
            code_s1 <= afe_code;
            code_s2 <= code_s1;
            smp_div <= (smp_div == 3'(`SAS_SMP_DIV - 1) || !afe_sample) ? 3'h0 : smp_div + 3'h1;
        end
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_comb begin
        next_state = state;
        next_cyc = cyc;
        next_step = step;
        next_avg_n = avg_n;
        next_acc = acc;
        next_conv_a = conv_a;
        next_conv_b = conv_b;
        next_div_start = 1'b0;
        next_div_num = div_num;
        next_div_den = div_den;
        next_result = result;
        done_pulse = 1'b0;
        case (state)
            SAS_ST_IDLE: begin
                if (enable && (start_req || cont)) begin
                    next_state = SAS_ST_CONV;
                    next_cyc = 8'h00;
                    next_step = 2'd0;
                    next_avg_n = 4'h0;
                    next_acc = 14'h0000;
                end
            end
            SAS_ST_CONV: begin
                next_cyc = cyc + 8'h01;
                if (cyc == 8'(`SAS_CONV_CYCLES - 1)) begin
                    next_acc = acc + {4'h0, code_s2};
                    next_avg_n = avg_n + 4'h1;
                    next_cyc = 8'h00;
                    if (avg_n == 4'((4'h1 << avg_log) - 4'h1)) begin
                        next_state = SAS_ST_NEXT;
                    end
                end
            end
            SAS_ST_NEXT: begin
                next_acc = 14'h0000;
                next_avg_n = 4'h0;
                if (step == 2'd0) begin
                    next_conv_a = avg_code;
                end else if (step == 2'd1) begin
                    next_conv_b = avg_code;
                end
                if (step == last_step) begin
                    case (mode)
                        SAS_MODE_ABS: begin
                            next_result = avg_code;
                            next_state = SAS_ST_DONE;
                        end
                        SAS_MODE_RATIO: begin
                            next_div_num = {1'b0, conv_a};
                            next_div_den = avg_code;
                            next_div_start = 1'b1;
                            next_state = SAS_ST_DIV;
                        end
                        SAS_MODE_PDIFF: begin
                            next_result = (conv_a > avg_code) ? conv_a - avg_code : 10'h000;
                            next_state = SAS_ST_DONE;
                        end
                        default: begin
                            next_div_num = diff[10] ? 11'h000 : diff;
                            next_div_den = avg_code;
                            next_div_start = 1'b1;
                            next_state = SAS_ST_DIV;
                        end
                    endcase
                end else begin
                    next_step = step + 2'd1;
                    next_state = SAS_ST_CONV;
                end
            end
            SAS_ST_DIV: begin
                if (div_done) begin
                    // Ratio of one or more saturates, zero reference included
                    next_result = ({1'b0, div_den} <= div_num) ? 10'h3FF : div_quot;
                    next_state = SAS_ST_DONE;
                end
            end
            SAS_ST_DONE: begin
                done_pulse = 1'b1;
                next_state = (cont && enable) ? SAS_ST_CONV : SAS_ST_IDLE;
                next_step = 2'd0;
                next_cyc = 8'h00;
            end
            default: next_state = SAS_ST_IDLE;
        endcase
        if (!enable && state != SAS_ST_DONE) begin
            next_state = SAS_ST_IDLE;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state <= SAS_ST_IDLE;
            cyc <= 8'h00;
            step <= 2'd0;
            avg_n <= 4'h0;
            acc <= 14'h0000;
            conv_a <= 10'h000;
            conv_b <= 10'h000;
            div_start <= 1'b0;
            div_num <= 11'h000;
            div_den <= 10'h000;
            result <= 10'h000;
        end else begin
            state <= next_state;
            cyc <= next_cyc;
            step <= next_step;
            avg_n <= next_avg_n;
            acc <= next_acc;
            conv_a <= next_conv_a;
            conv_b <= next_conv_b;
            div_start <= next_div_start;
            div_num <= next_div_num;
            div_den <= next_div_den;
            result <= next_result;
        end
    end

    sas_div u_div (
        .sys_clk(sys_clk),
        .rst(rst),
        .start(div_start),
        .num(div_num),
        .den(div_den),
        .done(div_done),
        .quot(div_quot)
    );

    // ----------------------------------------
    // Register file
    // ----------------------------------------
    always_comb begin
        next_enable = enable;
        next_cont = cont;
        next_start_req = start_req;
        next_cfg = cfg;
        next_irq_mask = irq_mask;
        next_irq_stat = irq_stat;
        next_readdata = 32'h0000_0000;
        next_rd_ack = 1'b0;
        if (state == SAS_ST_IDLE && next_state == SAS_ST_CONV) begin
            next_start_req = 1'b0;
        end
        if (req.write) begin
            case (req.address)
                `SAS_OFF_CTRL: begin
                    next_enable = req.writedata[`SAS_CTRL_ENABLE];
                    next_cont = req.writedata[`SAS_CTRL_CONT];
                    next_start_req = req.writedata[`SAS_CTRL_START];
                end
                `SAS_OFF_CFG: next_cfg = req.writedata;
                `SAS_OFF_IRQ_STAT: begin
                    if (req.writedata[0]) begin
                        next_irq_stat = 1'b0;
                    end
                end
                `SAS_OFF_IRQ_MASK: next_irq_mask = req.writedata[0];
                default: ;
            endcase
        end
        if (done_pulse) begin
            next_irq_stat = 1'b1;
        end
        if (req.read && !rd_ack) begin
            next_rd_ack = 1'b1;
            case (req.address)
                `SAS_OFF_CTRL: next_readdata = {29'h0, cont, enable, start_req};
                `SAS_OFF_CFG: next_readdata = cfg;
                `SAS_OFF_STAT: begin
                    // Busy drops as the result lands
                    next_readdata = {31'h0, state != SAS_ST_IDLE && state != SAS_ST_DONE};
                end
                `SAS_OFF_RESULT: next_readdata = {22'h0, result};
                `SAS_OFF_IRQ_STAT: next_readdata = {31'h0, irq_stat};
                `SAS_OFF_IRQ_MASK: next_readdata = {31'h0, irq_mask};
                default: next_readdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            enable <= 1'b0;
            cont <= 1'b0;
            start_req <= 1'b0;
            cfg <= `SAS_CFG_RST;
            irq_stat <= 1'b0;
            irq_mask <= 1'b0;
            avs_readdata <= 32'h0000_0000;
            rd_ack <= 1'b0;
        end else begin
            enable <= next_enable;
            cont <= next_cont;
            start_req <= next_start_req;
            cfg <= next_cfg;
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            avs_readdata <= next_readdata;
            rd_ack <= next_rd_ack;
        end
    end

    assign avs_waitrequest = avs_read && !rd_ack;
    assign irq = irq_stat && irq_mask;
endmodule

// *** verif/sas_checker.sv ***
// Port-level assertions of the converter sequencer
`include "sas_defs.svh"
module sas_checker (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Register bus
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Front end and interrupt
    input wire sas_pkg::sas_sel_t afe_sel,
    input wire logic afe_smp_clk,
    input wire logic afe_sample,
    input wire logic [9:0] afe_code,
    input wire logic irq
);
    import sas_pkg::*;
    logic [7:0] run_len;
    logic aborted;
    logic cont_on;
    logic ctl_wr;
    logic smp_q;
    assign ctl_wr = avs_write && avs_address == `SAS_OFF_CTRL;
    // Run length, abort and continuous tracking
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            run_len <= 8'h00;
            aborted <= 1'b0;
            cont_on <= 1'b0;
            smp_q <= 1'b0;
        end else begin
            smp_q <= afe_sample;
            // Counts within one conversion, so averaged runs wrap
            if (!afe_sample || run_len == 8'(`SAS_CONV_CYCLES - 1)) begin
                run_len <= 8'h00;
            end else begin
                run_len <= run_len + 8'h01;
            end
            if (ctl_wr && !avs_writedata[1]) begin
                aborted <= 1'b1;
            end else if (afe_sample && !smp_q) begin
                aborted <= 1'b0;
            end
            if (ctl_wr) begin
                cont_on <= avs_writedata[1] && avs_writedata[2];
            end
        end
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    property p_conv_len;
        $fell(afe_sample) && !aborted |-> run_len == 8'h00;
    endproperty
    a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");
    property p_smp_gate;
        !afe_sample |-> !afe_smp_clk;
    endproperty
    a_smp_gate: assert property (p_smp_gate) else $error("sample clock outside conversion");
    property p_smp_shape;
        $rose(afe_smp_clk) |=> (afe_smp_clk || !afe_sample) ##1 !afe_smp_clk [*2];
    endproperty
    a_smp_shape: assert property (p_smp_shape) else $error("sample clock shape wrong");
    property p_busy_read;
        avs_read && !avs_waitrequest && avs_address == `SAS_OFF_STAT
            && afe_sample && $past(afe_sample) |-> avs_readdata[0];
    endproperty
    a_busy_read: assert property (p_busy_read) else $error("busy low while converting");
    property p_read_wait;
        $rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest;
    endproperty
    a_read_wait: assert property (p_read_wait) else $error("read answer timing wrong");
    property p_scale_int;
        afe_sel.chan >= 3'h4 |-> afe_sel.scale == 3'h0;
    endproperty
    a_scale_int: assert property (p_scale_int) else $error("scale on internal input");
    property p_chan_range;
        afe_sample |-> afe_sel.chan <= 3'h5;
    endproperty
    a_chan_range: assert property (p_chan_range) else $error("input select out of range");
    property p_irq_mask;
        avs_write && avs_address == `SAS_OFF_IRQ_MASK && !avs_writedata[0] |=> ##1 !irq;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("masked interrupt still high");
    property p_cont;
        $fell(afe_sample) && cont_on |-> ##[1:40] (afe_sample || !cont_on);
    endproperty
    a_cont: assert property (p_cont) else $error("continuous run did not restart");
endmodule

bind sas_top sas_checker sas_checker_inst (
    .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .afe_sel(afe_sel), .afe_smp_clk(afe_smp_clk),
    .afe_sample(afe_sample), .afe_code(afe_code), .irq(irq)
);

// *** verif/sas_afe_model.sv ***
// Behavioural analog front end answering the sequencer's conversions
`include "sas_defs.svh"
module sas_afe_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Bench control
    input wire logic clr,
    input wire logic [29:0] codes,
    output logic [3:0] n_conv,
    output sas_pkg::sas_sel_t first_sel,
    // Sequencer side
    input wire sas_pkg::sas_sel_t afe_sel,
    input wire logic afe_sample,
    output logic [9:0] afe_code
);
    import sas_pkg::*;
    logic [7:0] cnt;
    always_ff @(posedge sys_clk) begin
        if (rst || clr) begin
            n_conv <= 4'h0;
            afe_code <= 10'h155;
            cnt <= 8'h00;
        end else if (afe_sample) begin
            // One code per conversion, averaged ones included
            cnt <= (cnt == 8'(`SAS_CONV_CYCLES - 1)) ? 8'h00 : cnt + 8'h01;
            if (cnt == 8'h00) begin
                afe_code <= (n_conv == 4'h0) ? codes[9:0] :
                    (n_conv == 4'h1) ? codes[19:10] : codes[29:20];
                n_conv <= n_conv + 4'h1;
                if (n_conv == 4'h0) begin
                    first_sel <= afe_sel;
                end
            end
        end else begin
            // Released line toggles so stale codes are never read
            cnt <= 8'h00;
            afe_code <= ~afe_code;
        end
    end
endmodule

// *** verif/sas_top_tb.sv ***
// Self-checking bench of the converter sequencer
`include "sas_defs.svh"
module sas_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import sas_pkg::*;
    typedef struct {
        logic [31:0] cfg;
        logic [29:0] codes;
        logic [9:0] res;
        logic [3:0] n;
        logic [2:0] scl;
    } sas_row_t;
    logic sys_clk, rst, avs_read, avs_write, afe_smp_clk, afe_sample, irq, avs_waitrequest, clr;
    logic [3:0] avs_address, n_conv, snap;
    logic [31:0] avs_writedata, avs_readdata, d;
    logic [29:0] codes;
    logic [9:0] afe_code;
    sas_sel_t afe_sel, first_sel;
    sas_row_t rows [8];
    logic [3:0] regs [6];
    int mismatches, n_checks, cyc;
    sas_top sas_top_inst (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .afe_sel(afe_sel),
        .afe_smp_clk(afe_smp_clk), .afe_sample(afe_sample), .afe_code(afe_code), .irq(irq));
    sas_afe_model sas_afe_model_inst (.sys_clk(sys_clk), .rst(rst), .clr(clr), .codes(codes),
        .n_conv(n_conv), .first_sel(first_sel), .afe_sel(afe_sel), .afe_sample(afe_sample),
        .afe_code(afe_code));
    // ----
    // Tasks
    // ----
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus_wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        avs_write <= 1'b1;
        avs_address <= a;
        avs_writedata <= v;
        @(negedge sys_clk);
        while (avs_waitrequest) @(negedge sys_clk);
        @(posedge sys_clk);
        avs_write <= 1'b0;
    endtask
    task automatic bus_rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge sys_clk);
        avs_read <= 1'b1;
        avs_address <= a;
        @(negedge sys_clk);
        while (avs_waitrequest) @(negedge sys_clk);
        v = avs_readdata;
        @(posedge sys_clk);
        avs_read <= 1'b0;
    endtask
    task automatic load(input logic [29:0] c);
        codes <= c;
        clr <= 1'b1;
        @(posedge sys_clk);
        clr <= 1'b0;
    endtask
    task automatic run_seq(input logic [31:0] cfg, input logic [29:0] c);
        logic [31:0] s;
        bus_wr(`SAS_OFF_CFG, cfg);
        load(c);
        repeat (23) @(posedge sys_clk);
        bus_wr(`SAS_OFF_CTRL, 32'h3);
        s = 32'h1;
        while (s[0] !== 1'b0) bus_rd(`SAS_OFF_STAT, s);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    always #25 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            give_verdict();
        end
    end
    // ----
    // Sequence
    // ----
    initial begin
        sys_clk = 0;
        rst = 1;
        {avs_read, avs_write, avs_address, avs_writedata, codes, clr} = '0;
        {mismatches, n_checks, cyc} = '0;
        regs = '{`SAS_OFF_CFG, `SAS_OFF_STAT, `SAS_OFF_RESULT, `SAS_OFF_IRQ_STAT,
            `SAS_OFF_IRQ_MASK, 4'hF};
        rows = '{'{32'h0000_0031, {20'h0, 10'h2A5}, 10'h2A5, 4'h1, 3'h3},
            '{32'h0000_0075, {20'h0, 10'h3FF}, 10'h3FF, 4'h1, 3'h0},
            '{32'h0000_0102, {10'h0, 10'h200, 10'h100}, 10'h200, 4'h2, 3'h0},
            '{32'h0001_0103, {10'h0, 10'h100, 10'h300}, 10'h3FF, 4'h2, 3'h0},
            '{32'h0020_0200, {10'h0, 10'h100, 10'h300}, 10'h200, 4'h2, 3'h0},
            '{32'h0030_0211, {10'h0, 10'h060, 10'h050}, 10'h000, 4'h2, 3'h1},
            '{32'h0012_0300, {10'h200, 10'h080, 10'h180}, 10'h200, 4'h3, 3'h0},
            '{32'h0000_1054, {10'h0, 10'h102, 10'h100}, 10'h101, 4'h2, 3'h0}};
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        bus_wr(4'hF, 32'hFFFF_FFFF);
        foreach (regs[i]) begin
            bus_rd(regs[i], d);
            chk(d, 32'h0);
        end
        $display("test reset done");
        bus_wr(`SAS_OFF_IRQ_MASK, 32'h1);
        for (int i = 0; i < 8; i++) begin
            run_seq(rows[i].cfg, rows[i].codes);
            bus_rd(`SAS_OFF_RESULT, d);
            chk(d, {22'h0, rows[i].res});
            chk({28'h0, n_conv}, {28'h0, rows[i].n});
            chk({29'h0, first_sel.chan}, {29'h0, rows[i].cfg[2:0]});
            chk({29'h0, first_sel.scale}, {29'h0, rows[i].scl});
            chk({26'h0, first_sel.ref_chan, first_sel.neg_chan},
                {26'h0, rows[i].cfg[18:16], rows[i].cfg[22:20]});
            chk({31'h0, irq}, 32'h1);
            bus_wr(`SAS_OFF_IRQ_STAT, 32'h1);
            repeat (150) @(posedge sys_clk);
            chk({31'h0, irq}, 32'h0);
            chk({28'h0, n_conv}, {28'h0, rows[i].n});
            $display("test row %0d done", i);
        end
        bus_wr(`SAS_OFF_IRQ_MASK, 32'h0);
        run_seq(rows[0].cfg, rows[0].codes);
        chk({31'h0, irq}, 32'h0);
        bus_rd(`SAS_OFF_IRQ_STAT, d);
        chk(d, 32'h1);
        bus_wr(`SAS_OFF_IRQ_MASK, 32'h1);
        repeat (2) @(posedge sys_clk);
        chk({31'h0, irq}, 32'h1);
        bus_wr(`SAS_OFF_IRQ_STAT, 32'h1);
        repeat (2) @(posedge sys_clk);
        chk({31'h0, irq}, 32'h0);
        $display("test mask done");
        bus_wr(`SAS_OFF_CTRL, 32'h3);
        repeat (30) @(posedge sys_clk);
        bus_wr(`SAS_OFF_CTRL, 32'h0);
        bus_rd(`SAS_OFF_STAT, d);
        chk(d, 32'h0);
        bus_rd(`SAS_OFF_IRQ_STAT, d);
        chk(d, 32'h0);
        $display("test abort done");
        load({3{10'h2A5}});
        bus_wr(`SAS_OFF_CTRL, 32'h6);
        while (n_conv < 4'h3) @(posedge sys_clk);
        bus_wr(`SAS_OFF_CTRL, 32'h0);
        repeat (5) @(posedge sys_clk);
        snap = n_conv;
        repeat (400) @(posedge sys_clk);
        chk({28'h0, n_conv}, {28'h0, snap});
        bus_rd(`SAS_OFF_RESULT, d);
        chk(d, 32'h2A5);
        bus_rd(`SAS_OFF_STAT, d);
        chk(d, 32'h0);
        $display("test continuous done");
        give_verdict();
    end
endmodule
